/* core/emtm_core.sv */
`timescale 1ns/100ps
`default_nettype none
`include "emtm_defines.svh"
module emtm_core #(
    parameter int unsigned STALL_CYCLES = `EMTM_STALL_US * `EMTM_CLK_MHZ,
    parameter int unsigned FAST_CYCLES =
        `EMTM_INTV_FAST_MS * 1000 * `EMTM_CLK_MHZ,
    parameter int unsigned SLOW_CYCLES =
        `EMTM_INTV_SLOW_S * 1000000 * `EMTM_CLK_MHZ,
    parameter int unsigned RST_CYCLES = `EMTM_RST_PULSE_CYCLES
)(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Emulated bus cycles and target lines
    input wire emtm_pkg::emtm_bus_cycle_s bus_cycle_in,
    input wire emtm_pkg::emtm_target_s target_in,
    // Probe, clock control and interrupt
    output logic trigger_n_out,
    output emtm_pkg::emtm_clk_src_e clock_select_out,
    output logic proc_reset_n_out,
    output logic irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // Bus slave state
    logic dp_valid_reg, dp_valid_next;
    logic dp_write_reg, dp_write_next;
    logic [7:0] dp_addr_reg, dp_addr_next;
    logic addr_take;
    logic wr_ctrl, wr_clock, wr_mask, rd_events;

    // Register state
    logic [31:0] ctrl_reg, ctrl_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] events_reg, events_next;
    logic [7:0] ev_set;
    logic check_req;
    logic run;
    emtm_pkg::emtm_intv_e intv;

    // Clock sequencer state
    emtm_pkg::emtm_clk_state_e state_reg, state_next;
    emtm_pkg::emtm_clk_src_e src_reg, src_next, req_src;
    logic [31:0] rst_cnt_reg, rst_cnt_next;
    logic clk_switch, clk_err;

    // Trigger, monitor and check state
    logic trig_low_reg, trig_low_next;
    logic trace_hit, brk_hit;
    logic [7:0] fault_reg, fault_next;
    logic [7:0] lines_n;
    logic [31:0] intv_cnt_reg, intv_cnt_next, intv_limit;
    logic [31:0] stall_cnt_reg, stall_cnt_next;
    logic [31:0] pc_reg, pc_next;
    logic [31:0] stall_addr_reg, stall_addr_next;
    logic [31:0] wait_addr_reg, wait_addr_next;
    logic vcc_down_reg, vcc_down;
    logic wait_st, clk_loss, sample_due, stall_hit, vcc_back;

    // Address phase is taken only with hready high; zero wait states
    assign addr_take = hsel_in & htrans_in[1] & hready_in;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign wr_ctrl = dp_valid_reg & dp_write_reg
        & (dp_addr_reg == `EMTM_OFS_CTRL);
    assign wr_clock = dp_valid_reg & dp_write_reg
        & (dp_addr_reg == `EMTM_OFS_CLOCK);
    assign wr_mask = dp_valid_reg & dp_write_reg
        & (dp_addr_reg == `EMTM_OFS_MASK);
    assign rd_events = dp_valid_reg & ~dp_write_reg
        & (dp_addr_reg == `EMTM_OFS_EVENTS);

    // Next address phase capture
    always_comb
    begin
        dp_valid_next = addr_take;
        dp_write_next = addr_take & hwrite_in;
        dp_addr_next = addr_take ? haddr_in[7:0] : dp_addr_reg;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end
        else
        begin
            dp_valid_reg <= dp_valid_next;
            dp_write_reg <= dp_write_next;
            dp_addr_reg <= dp_addr_next;
        end
    end

    // Read mux in the data phase; reads of the event word see it pre-clear
    always_comb
    begin
        hrdata_out = 32'h0000_0000;
        if (dp_valid_reg & ~dp_write_reg)
        begin
            unique case (dp_addr_reg)
                `EMTM_OFS_CTRL: hrdata_out = ctrl_reg;
                `EMTM_OFS_CLOCK: hrdata_out = {30'h0, src_reg};
                `EMTM_OFS_STATUS: hrdata_out = {14'h0, src_reg, fault_reg,
                    1'b0, (stall_cnt_reg >= STALL_CYCLES), clk_loss,
                    vcc_down, ~target_in.bus_request_n,
                    ~target_in.processor_reset_n, wait_st,
                    ~proc_reset_n_out};
                `EMTM_OFS_EVENTS: hrdata_out = {24'h0, events_reg};
                `EMTM_OFS_MASK: hrdata_out = {24'h0, mask_reg};
                `EMTM_OFS_PC: hrdata_out = pc_reg;
                `EMTM_OFS_STALL: hrdata_out = stall_addr_reg;
                `EMTM_OFS_WAIT: hrdata_out = wait_addr_reg;
                default: hrdata_out = 32'h0000_0000;
            endcase
        end
    end

    // Software controls; check bit is a self-clearing request
    assign check_req = wr_ctrl & hwdata_in[`EMTM_CTRL_CHECK];
    assign run = ctrl_reg[`EMTM_CTRL_RUN];
    assign intv = emtm_pkg::emtm_intv_e'(ctrl_reg[`EMTM_CTRL_INTV_LO +: 2]);
    assign irq_out = |(events_reg & mask_reg);

    // A set arriving with the read-clear wins, so no event is lost
    always_comb
    begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (wr_ctrl)
            ctrl_next = hwdata_in & `EMTM_CTRL_WMASK;
        if (wr_mask)
            mask_next = hwdata_in[7:0];
        events_next = (rd_events ? 8'h00 : events_reg) | ev_set;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_reg <= `EMTM_CTRL_RESET;
            mask_reg <= 8'h00;
            events_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            events_reg <= events_next;
        end
    end

    // Requested source; the unused code falls to internal
    always_comb
    begin
        unique case (hwdata_in[1:0])
            2'h1: req_src = emtm_pkg::CLK_CRYSTAL;
            2'h2: req_src = emtm_pkg::CLK_TARGET;
            default: req_src = emtm_pkg::CLK_INTERNAL;
        endcase
    end

    // Clock sequencer: every switch holds the processor in reset
    always_comb
    begin
        state_next = state_reg;
        src_next = src_reg;
        rst_cnt_next = rst_cnt_reg;
        clk_switch = 1'b0;
        clk_err = 1'b0;
        unique case (state_reg)
            emtm_pkg::CS_START:
            begin
                clk_switch = 1'b1;
                if (target_in.clock_present)
                    src_next = emtm_pkg::CLK_TARGET;
                else if (target_in.crystal_fitted)
                    src_next = emtm_pkg::CLK_CRYSTAL;
                else
                    src_next = emtm_pkg::CLK_INTERNAL;
            end
            emtm_pkg::CS_READY:
            begin
                if (wr_clock)
                begin
                    clk_switch = 1'b1;
                    src_next = req_src;
                    if (req_src == emtm_pkg::CLK_TARGET
                        && !target_in.clock_present)
                    begin
                        src_next = emtm_pkg::CLK_INTERNAL;
                        clk_err = 1'b1;
                    end
                end
                else if (vcc_down && !run)
                begin
                    src_next = emtm_pkg::CLK_INTERNAL;
                    clk_switch = 1'b1;
                end
            end
            emtm_pkg::CS_HOLD:
            begin
                rst_cnt_next = rst_cnt_reg - 32'h0000_0001;
                if (rst_cnt_reg <= 32'h0000_0001)
                    state_next = emtm_pkg::CS_READY;
            end
        endcase
        if (clk_switch)
        begin
            state_next = emtm_pkg::CS_HOLD;
            rst_cnt_next = RST_CYCLES;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= emtm_pkg::CS_START;
            src_reg <= emtm_pkg::CLK_INTERNAL;
            rst_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            src_reg <= src_next;
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    // Processor runs only once the sequencer has settled
    assign proc_reset_n_out = (state_reg == emtm_pkg::CS_READY);
    assign clock_select_out = src_reg;

    // Trigger: level only moves at bus cycle ends
    assign trace_hit = (ctrl_reg[`EMTM_CTRL_TRGBUS]
        & bus_cycle_in.trace_bus_match)
        | (ctrl_reg[`EMTM_CTRL_TRGUSR]
        & bus_cycle_in.trace_user_match);
    // Software breaks are deliberately not part of the hit term
    assign brk_hit = run & bus_cycle_in.hw_break;

    always_comb
    begin
        trig_low_next = trig_low_reg;
        if (bus_cycle_in.cycle_end)
            trig_low_next = trace_hit | brk_hit;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            trig_low_reg <= 1'b0;
        else
            trig_low_reg <= trig_low_next;
    end

    assign trigger_n_out = ~trig_low_reg;

    // Supply and clock watch; a dead supply masks clock loss
    assign vcc_down = (src_reg == emtm_pkg::CLK_TARGET) & ~target_in.vcc_ok;
    assign clk_loss = (src_reg == emtm_pkg::CLK_TARGET) & target_in.vcc_ok
        & ~target_in.clock_present;
    assign vcc_back = vcc_down_reg & ~vcc_down & run;
    assign wait_st = run & ~target_in.wait_n & ~bus_cycle_in.mem_cmd
        & ~bus_cycle_in.refresh;
    assign lines_n = {target_in.processor_reset_n, target_in.bus_request_n,
        target_in.wait_n, target_in.interrupt_level_inputs_n,
        target_in.nmi_n};
    assign intv_limit = (intv == emtm_pkg::INTV_SLOW) ? SLOW_CYCLES
        : FAST_CYCLES;
    assign sample_due = run & (intv == emtm_pkg::INTV_FAST
        || intv == emtm_pkg::INTV_SLOW)
        & (intv_cnt_reg >= intv_limit - 32'h0000_0001);
    assign stall_hit = run & ~bus_cycle_in.cycle_end
        & (stall_cnt_reg == STALL_CYCLES - 32'h0000_0001);

    // Events raised by the watchers
    always_comb
    begin
        ev_set = 8'h00;
        ev_set[`EMTM_EV_TRIG] = trig_low_next & ~trig_low_reg;
        ev_set[`EMTM_EV_CLKERR] = clk_err;
        ev_set[`EMTM_EV_STALL] = stall_hit;
        ev_set[`EMTM_EV_VCCDOWN] = vcc_down & ~vcc_down_reg & run;
        ev_set[`EMTM_EV_VCCBACK] = vcc_back;
        ev_set[`EMTM_EV_SAMPLE] = sample_due;
        ev_set[`EMTM_EV_CHECK] = check_req
            | (state_reg == emtm_pkg::CS_START);
        ev_set[`EMTM_EV_CLKLOSS] = clk_loss;
    end

    // Monitor counters and captured addresses
    always_comb
    begin
        intv_cnt_next = intv_cnt_reg + 32'h0000_0001;
        if (!run || sample_due)
            intv_cnt_next = 32'h0000_0000;
        stall_cnt_next = stall_cnt_reg;
        if (!run || bus_cycle_in.cycle_end)
            stall_cnt_next = 32'h0000_0000;
        else if (stall_cnt_reg < STALL_CYCLES)
            stall_cnt_next = stall_cnt_reg + 32'h0000_0001;
        pc_next = pc_reg;
        if (sample_due || vcc_back)
            pc_next = bus_cycle_in.fetch_addr;
        stall_addr_next = stall_hit ? bus_cycle_in.addr : stall_addr_reg;
        wait_addr_next = wait_st ? bus_cycle_in.addr : wait_addr_reg;
        fault_next = fault_reg;
        if (check_req || state_reg == emtm_pkg::CS_START)
            fault_next = ~lines_n;
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            intv_cnt_reg <= 32'h0000_0000;
            stall_cnt_reg <= 32'h0000_0000;
            pc_reg <= 32'h0000_0000;
            stall_addr_reg <= 32'h0000_0000;
            wait_addr_reg <= 32'h0000_0000;
            fault_reg <= 8'h00;
            vcc_down_reg <= 1'b0;
        end
        else
        begin
            intv_cnt_reg <= intv_cnt_next;
            stall_cnt_reg <= stall_cnt_next;
            pc_reg <= pc_next;
            stall_addr_reg <= stall_addr_next;
            wait_addr_reg <= wait_addr_next;
            fault_reg <= fault_next;
            vcc_down_reg <= vcc_down;
        end
    end

    // Checks on the trigger probe
    a_trig_hit_low: assert property (
        bus_cycle_in.cycle_end && trace_hit |=> !trigger_n_out)
        else $error("trace hit did not pull trigger low");
    a_trig_end_rise: assert property (
        bus_cycle_in.cycle_end && !trace_hit && !brk_hit
        |=> trigger_n_out)
        else $error("trigger not released at cycle end");
    a_trig_held_low: assert property (
        !trigger_n_out && !bus_cycle_in.cycle_end |=> !trigger_n_out)
        else $error("trigger pulse broke inside a cycle");
    a_break_trig: assert property (
        run && bus_cycle_in.hw_break && bus_cycle_in.cycle_end
        |=> !trigger_n_out ##0 events_reg[`EMTM_EV_TRIG] || $past(trig_low_reg))
        else $error("hardware break gave no trigger");
    a_swbrk_quiet: assert property (
        bus_cycle_in.cycle_end && bus_cycle_in.sw_break && !trace_hit
        && !brk_hit |=> trigger_n_out)
        else $error("software break drove trigger");

    // Checks on clock switching, reset, line check, stall and supply return
    a_switch_reset: assert property (
        state_reg == emtm_pkg::CS_READY && wr_clock
        |=> !proc_reset_n_out [*8])
        else $error("clock switch without processor reset");
    a_clk_fallback: assert property (
        state_reg == emtm_pkg::CS_READY && wr_clock
        && req_src == emtm_pkg::CLK_TARGET && !target_in.clock_present
        |=> clock_select_out == emtm_pkg::CLK_INTERNAL
        && events_reg[`EMTM_EV_CLKERR])
        else $error("missing target clock not handled");
    a_start_order: assert property (
        state_reg == emtm_pkg::CS_START && !target_in.clock_present
        && target_in.crystal_fitted
        |=> clock_select_out == emtm_pkg::CLK_CRYSTAL)
        else $error("start clock priority wrong");
    a_check_lines: assert property (
        check_req |=> fault_reg == ~$past(lines_n))
        else $error("line check result wrong");
    a_stall_flag: assert property (
        stall_hit |=> events_reg[`EMTM_EV_STALL]
        && stall_addr_reg == $past(bus_cycle_in.addr))
        else $error("stall not flagged");
    a_idle_power: assert property (
        state_reg == emtm_pkg::CS_READY && vcc_down && !run && !wr_clock
        |=> clock_select_out == emtm_pkg::CLK_INTERNAL && !proc_reset_n_out)
        else $error("idle supply loss not handled");
    a_power_back: assert property (
        vcc_back |=> pc_reg == $past(bus_cycle_in.fetch_addr)
        && events_reg[`EMTM_EV_VCCBACK])
        else $error("program counter not reported on power return");

    // Main scenarios
    c_trig_chain: cover property (
        !trigger_n_out && bus_cycle_in.cycle_end && trace_hit);
    c_clk_fallback: cover property (clk_err);
    c_stall: cover property (stall_hit);
    c_power_back: cover property (vcc_back);
endmodule // emtm_core
`default_nettype wire

/* core/emtm_defines.svh */
`ifndef EMTM_DEFINES_SVH
`define EMTM_DEFINES_SVH
// Notes on behaviour
// - With a trace trigger option on, a matching bus cycle pulls the trigger low.
// - A pulse starts at the end of the hit cycle and ends at the end of the next one.
// - Hits in back-to-back bus cycles keep the trigger low without a gap.
// - While running, a hardware break hit also starts a low trigger pulse.
// - A software break hit never produces a trigger pulse.
// - Every change of the emulation clock source asserts the processor reset.
// - Asking for the target clock while it is absent flags an error and selects internal.
// - At start the source is target clock, else pod crystal, else internal 15 MHz.
// - At start and on request the reset, bus request, wait, IRL and NMI lines are tested.
// - While running the fetch address is sampled every 200 ms, 2 s or never; 200 ms default.
// - While running, no progress for 80 us or longer flags a stall and captures the address.
// - While running, a low wait line shows wait status with the address, except for memory commands or refresh.
// - Reset status shows while the reset line is low, bus request status while it is low.
// - On the target clock, supply loss is seen before clock loss.
// - Supply loss while idle switches to the internal clock and resets the processor.
// - Supply loss while running flags supply down; on return the program counter is reported.

// Timing
`define EMTM_CLK_MHZ 250
`define EMTM_STALL_US 80
`define EMTM_INTV_FAST_MS 200
`define EMTM_INTV_SLOW_S 2
`define EMTM_RST_PULSE_CYCLES 16

// Register byte offsets
`define EMTM_OFS_CTRL 8'h00
`define EMTM_OFS_CLOCK 8'h04
`define EMTM_OFS_STATUS 8'h08
`define EMTM_OFS_EVENTS 8'h0C
`define EMTM_OFS_MASK 8'h10
`define EMTM_OFS_PC 8'h14
`define EMTM_OFS_STALL 8'h18
`define EMTM_OFS_WAIT 8'h1C

// Control fields and reset value
`define EMTM_CTRL_RUN 0
`define EMTM_CTRL_TRGBUS 1
`define EMTM_CTRL_TRGUSR 2
`define EMTM_CTRL_INTV_LO 4
`define EMTM_CTRL_CHECK 8
`define EMTM_CTRL_WMASK 32'h0000_0037
`define EMTM_CTRL_RESET 32'h0000_0010

// Event bits
`define EMTM_EV_TRIG 0
`define EMTM_EV_CLKERR 1
`define EMTM_EV_STALL 2
`define EMTM_EV_VCCDOWN 3
`define EMTM_EV_VCCBACK 4
`define EMTM_EV_SAMPLE 5
`define EMTM_EV_CHECK 6
`define EMTM_EV_CLKLOSS 7
`define EMTM_EV_WIDTH 8
`endif

/* core/emtm_pkg.sv */
package emtm_pkg;
    // Emulation clock source as seen in the clock register
    typedef enum logic [1:0] {
        CLK_INTERNAL = 2'h0,
        CLK_CRYSTAL = 2'h1,
        CLK_TARGET = 2'h2
    } emtm_clk_src_e;
    // Clock switch sequencer
    typedef enum logic [1:0] {CS_START, CS_READY, CS_HOLD} emtm_clk_state_e;
    // Address sampling interval option
    typedef enum logic [1:0] {
        INTV_OFF = 2'h0,
        INTV_FAST = 2'h1,
        INTV_SLOW = 2'h2
    } emtm_intv_e;
    // One emulated processor bus cycle
    typedef struct packed {
        logic cycle_end;
        logic trace_bus_match;
        logic trace_user_match;
        logic hw_break;
        logic sw_break;
        logic mem_cmd;
        logic refresh;
        logic [31:0] fetch_addr;
        logic [31:0] addr;
    } emtm_bus_cycle_s;
    // Target interface lines and pod straps
    typedef struct packed {
        logic processor_reset_n;
        logic bus_request_n;
        logic wait_n;
        logic [3:0] interrupt_level_inputs_n;
        logic nmi_n;
        logic clock_present;
        logic vcc_ok;
        logic crystal_fitted;
    } emtm_target_s;
endpackage

/* verif/emtm_target_model.sv */
`timescale 1ns/100ps
`default_nettype none
module emtm_target_model (
    // Clock
    input wire logic mclk_in,
    // Bench controls
    input wire logic cyc_req_in,
    input wire logic [4:0] cyc_flags_in,
    input wire logic power_on_in,
    input wire logic clock_on_in,
    input wire logic [2:0] lines_low_in,
    // Toward the design
    output var emtm_pkg::emtm_bus_cycle_s bus_cycle_out,
    output var emtm_pkg::emtm_target_s target_out
);
    logic [31:0] addr_reg = 32'h0000_1000;

    // Qualifiers only mean something with cycle_end, so scramble them between
    always_ff @(posedge mclk_in)
    begin
        addr_reg <= addr_reg + 32'h4;
        bus_cycle_out.cycle_end <= cyc_req_in;
        {bus_cycle_out.refresh, bus_cycle_out.sw_break, bus_cycle_out.hw_break,
         bus_cycle_out.trace_user_match, bus_cycle_out.trace_bus_match}
            <= cyc_req_in ? cyc_flags_in : {1'b0, addr_reg[5:2]};
        // Refresh and memory commands stay off between cycles
        bus_cycle_out.mem_cmd <= 1'b0;
        bus_cycle_out.fetch_addr <= addr_reg;
        bus_cycle_out.addr <= addr_reg;
    end

    // Supply and board clock drop together; the clock returns a cycle after the supply
    always_ff @(posedge mclk_in)
    begin
        target_out.vcc_ok <= power_on_in;
        target_out.clock_present <=
            clock_on_in & power_on_in & target_out.vcc_ok;
        target_out.processor_reset_n <= ~lines_low_in[2];
        target_out.bus_request_n <= ~lines_low_in[1];
        target_out.wait_n <= ~lines_low_in[0];
        target_out.interrupt_level_inputs_n <= 4'hF;
        target_out.nmi_n <= 1'h1;
        target_out.crystal_fitted <= 1'h1;
    end
endmodule // emtm_target_model
`default_nettype wire

/* verif/emtm_core_test.sv */
`timescale 1ns/100ps
`default_nettype none
module emtm_core_test;
    logic mclk_in, rst, hsel, hwrite, hrdy, trig_n, prst_n, irq;
    logic [1:0] htrans;
    logic [2:0] hsize, lines;
    logic [31:0] haddr, hwdata, hrdata, rd_s;
    logic rdy_s, cyc_req, pwr, clk_on, last_trig;
    logic [4:0] cyc_flags;
    emtm_pkg::emtm_bus_cycle_s bus;
    emtm_pkg::emtm_target_s tgt;
    emtm_pkg::emtm_clk_src_e sel;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    // {expected trigger, refresh, sw, hw, user, bus}
    localparam logic [5:0] STEPS [11] = '{6'h01, 6'h01, 6'h20, 6'h22, 6'h04,
        6'h28, 6'h11, 6'h02, 6'h24, 6'h21, 6'h20};

    emtm_core #(.STALL_CYCLES(20), .FAST_CYCLES(40), .SLOW_CYCLES(100),
        .RST_CYCLES(16)) dut (.mclk_in(mclk_in), .sys_rst_in(rst),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
        .hresp_out(), .bus_cycle_in(bus), .target_in(tgt),
        .trigger_n_out(trig_n), .clock_select_out(sel),
        .proc_reset_n_out(prst_n), .irq_out(irq));
    emtm_target_model board (.mclk_in(mclk_in), .cyc_req_in(cyc_req),
        .cyc_flags_in(cyc_flags), .power_on_in(pwr), .clock_on_in(clk_on),
        .lines_low_in(lines), .bus_cycle_out(bus), .target_out(tgt));

    // 250 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    // Bus answer latched mid-cycle so the edge sees a settled value
    always @(negedge mclk_in)
    begin
        rd_s = hrdata;
        rdy_s = hrdy;
    end

    // Hang guard
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One AHB-Lite single word transfer, waiting on hready each phase
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge mclk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk_in); while (rdy_s !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk_in); while (rdy_s !== 1'b1);
        rd = rd_s;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdchk(string w, logic [7:0] a, logic [31:0] m,
        logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(w, x & m, e);
    endtask

    task automatic pins(string w, logic [1:0] s, logic r);
        @(negedge mclk_in);
        check({w, " source"}, {30'h0, sel}, {30'h0, s});
        check({w, " reset"}, {31'h0, prst_n}, {31'h0, r});
    endtask

    // One emulated bus cycle; trigger must hold until the cycle is taken
    task automatic cyc(logic [4:0] f, logic e);
        @(posedge mclk_in);
        cyc_req <= 1'b1;
        cyc_flags <= f;
        @(posedge mclk_in);
        cyc_req <= 1'b0;
        @(negedge mclk_in);
        check("trigger held", {31'h0, trig_n}, {31'h0, last_trig});
        @(negedge mclk_in);
        check("trigger", {31'h0, trig_n}, {31'h0, e});
        last_trig = e;
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {rst, pwr, clk_on, last_trig} = 4'hF;
        {hsel, hwrite, cyc_req, lines, cyc_flags, htrans} = 12'h0;
        {haddr, hwdata, hsize} = {64'h0, 3'h2};
        repeat (4) @(posedge mclk_in);
        rst <= 1'b0;
        @(posedge mclk_in);
        pins("start", 2'h2, 1'b0);
        repeat (25) @(posedge mclk_in);
        pins("start", 2'h2, 1'b1);
        rdchk("ctrl", 8'h00, '1, 32'h10);
        rdchk("unmapped", 8'h40, '1, 32'h0);
        rdchk("status", 8'h08, '1, 32'h0002_0000);
        rdchk("events", 8'h0C, '1, 32'h40);
        rdchk("events", 8'h0C, '1, 32'h0);
        wr(8'h10, 32'h40);
        lines <= 3'h7;
        wr(8'h00, 32'h110);
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        check("irq", {31'h0, irq}, 32'h1);
        rdchk("status", 8'h08, 32'hFF0E, 32'hE00C);
        rdchk("check event", 8'h0C, 32'h40, 32'h40);
        @(negedge mclk_in);
        check("irq", {31'h0, irq}, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h100);
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        check("irq masked", {31'h0, irq}, 32'h0);
        lines <= 3'h0;
        $display("test start and check done");
        wr(8'h00, 32'h03);
        for (int i = 0; i < 11; i++)
        begin
            if (i == 7)
                wr(8'h00, 32'h04);
            cyc(STEPS[i][4:0], STEPS[i][5]);
        end
        rdchk("trig event", 8'h0C, 32'h1, 32'h1);
        $display("test trigger done");
        wr(8'h00, 32'h11);
        rdchk("clear", 8'h0C, 32'h0, 32'h0);
        repeat (45) @(posedge mclk_in);
        rdchk("fast", 8'h0C, 32'h24, 32'h24);
        rdchk("stall", 8'h08, 32'h40, 32'h40);
        wr(8'h00, 32'h21);
        rdchk("clear", 8'h0C, 32'h0, 32'h0);
        repeat (45) @(posedge mclk_in);
        rdchk("slow early", 8'h0C, 32'h20, 32'h0);
        repeat (60) @(posedge mclk_in);
        rdchk("slow", 8'h0C, 32'h20, 32'h20);
        wr(8'h00, 32'h01);
        rdchk("clear", 8'h0C, 32'h0, 32'h0);
        repeat (110) @(posedge mclk_in);
        rdchk("off", 8'h0C, 32'h20, 32'h0);
        $display("test monitor done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h1);
        repeat (2) @(posedge mclk_in);
        pins("crystal", 2'h1, 1'b0);
        repeat (25) @(posedge mclk_in);
        pins("crystal", 2'h1, 1'b1);
        clk_on <= 1'b0;
        wr(8'h04, 32'h2);
        repeat (2) @(posedge mclk_in);
        pins("no target", 2'h0, 1'b0);
        rdchk("clk error", 8'h0C, 32'h2, 32'h2);
        clk_on <= 1'b1;
        repeat (25) @(posedge mclk_in);
        wr(8'h04, 32'h2);
        repeat (25) @(posedge mclk_in);
        pins("target", 2'h2, 1'b1);
        $display("test clock done");
        pwr <= 1'b0;
        repeat (4) @(posedge mclk_in);
        pins("idle loss", 2'h0, 1'b0);
        pwr <= 1'b1;
        repeat (25) @(posedge mclk_in);
        wr(8'h04, 32'h2);
        repeat (25) @(posedge mclk_in);
        wr(8'h00, 32'h01);
        rdchk("clear", 8'h0C, 32'h0, 32'h0);
        pwr <= 1'b0;
        repeat (5) @(posedge mclk_in);
        rdchk("vcc status", 8'h08, 32'h10, 32'h10);
        rdchk("vcc down", 8'h0C, 32'h8, 32'h8);
        pwr <= 1'b1;
        repeat (5) @(posedge mclk_in);
        rdchk("vcc back", 8'h0C, 32'h10, 32'h10);
        lines <= 3'h1;
        repeat (3) @(posedge mclk_in);
        rdchk("wait", 8'h08, 32'h2, 32'h2);
        $display("test power done");
        rst <= 1'b1;
        clk_on <= 1'b0;
        lines <= 3'h0;
        repeat (2) @(posedge mclk_in);
        rst <= 1'b0;
        @(posedge mclk_in);
        pins("restart", 2'h1, 1'b0);
        $display("test restart done");
        report_and_stop();
    end
endmodule // emtm_core_test
`default_nettype wire
